// ---- hdl/pmp_clk_div.sv ----
// Module: management clock divider producing rise and fall tick pulses
`timescale 1ns/100ps
module pmp_clk_div #(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [DIV_W-1:0] divider,
    output logic tickRise,
    output logic tickFall
);
    import pmp_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic phase;
        logic rise;
        logic fall;
    } pmp_div_s;

    pmp_div_s s;
    pmp_div_s next_s;

    // ==========================================================
    // Divide the clock: a tick every divider+1 cycles, alternating rise and fall
    always_comb begin
        next_s = s;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (!enable) begin
            next_s.cnt = '0;
            next_s.phase = 1'b0;
        end else if (s.cnt == divider) begin
            next_s.cnt = '0;
            next_s.phase = ~s.phase;
            next_s.rise = ~s.phase;
            next_s.fall = s.phase;
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tickRise = s.rise;
    assign tickFall = s.fall;

endmodule

// ---- hdl/pmp_pkg.sv ----
// Package: constants and carrier types of the PHY management poller
package pmp_pkg;

    // ==========================================================
    // Clocking
    localparam int PMP_CLK_HZ = 50_000_000;
    localparam int PMP_MDC_MAX_HZ = 2_500_000;
    localparam int PMP_MDC_TYP_HZ = 1_000_000;
    localparam int PMP_DIV_W = 16;
    // Half period is divider+1 cycles; least divider keeping the bus at or under its ceiling
    localparam int PMP_DIV_FOR_MAX = (PMP_CLK_HZ + 2 * PMP_MDC_MAX_HZ - 1) / (2 * PMP_MDC_MAX_HZ) - 1;
    localparam int PMP_DIV_FOR_TYP = (PMP_CLK_HZ + 2 * PMP_MDC_TYP_HZ - 1) / (2 * PMP_MDC_TYP_HZ) - 1;

    // ==========================================================
    // Frame layout
    localparam logic [1:0] PMP_START = 2'h1;
    localparam logic [1:0] PMP_OP_READ = 2'h2;
    localparam logic [1:0] PMP_OP_WRITE = 2'h1;
    localparam logic [1:0] PMP_TA_WRITE = 2'h2;
    localparam logic [5:0] PMP_POS_FRAME = 6'h20;
    localparam logic [5:0] PMP_POS_TA = 6'h2E;
    localparam logic [5:0] PMP_POS_ACK = 6'h2F;
    localparam logic [5:0] PMP_POS_DATA = 6'h30;
    localparam logic [5:0] PMP_POS_LAST = 6'h3F;
    localparam logic [4:0] PMP_STATUS_REG = 5'h01;
    localparam int PMP_LINK_BIT = 2;
    localparam int PMP_PHYS = 32;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PMP_IDLE,
        PMP_FRAME,
        PMP_FINISH
    } pmp_frame_e;

    typedef struct packed {
        logic go;
        logic write;
        logic [4:0] regAddr;
        logic [4:0] phyAddr;
        logic [15:0] data;
    } pmp_cmd_s;

    typedef struct packed {
        logic go;
        logic write;
        logic ack;
        logic [4:0] regAddr;
        logic [4:0] phyAddr;
        logic [15:0] data;
    } pmp_slot_s;

endpackage

// ---- hdl/pmp_poller.sv ----
// Module: PHY management poller, serial management master with autopolling
// Behaviour
// - Enabled: poll all addresses' status register forever
// - Answering address sets its presence bit
// - Link bit needs answer and link up
// - User reads also update presence bit
// - Bus clock is peripheral clock divided
// - Idle until enable is set
// - Preamble sent unless option cleared
// - Monitored address link changes stored as event
// - Raw change bit; masked only if enabled
// - Go bit starts slot's read or write
// - Finish clears go, sets slot's done bit
// - Masked done bit follows set/clear mask
// - Two pending slots served round robin, interleaved
// - Write in one access; go low means done
// - Per-slot acknowledge readable
// - Read data and ack stored when go clears
`timescale 1ns/100ps
module pmp_poller #(
    parameter int DIV_W = pmp_pkg::PMP_DIV_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic preambleEn,
    input wire logic [DIV_W-1:0] mgmtClockDivider,
    input wire logic [1:0] accessReqStb,
    input wire pmp_pkg::pmp_cmd_s accessReq,
    input wire logic [1:0] accessDoneMaskSet,
    input wire logic [1:0] accessDoneMaskClear,
    input wire logic [1:0] accessDoneRawClear,
    input wire logic [4:0] monitoredPhyAddress,
    input wire logic carrierChangeIrqEn,
    input wire logic carrierChangeClear,
    input wire logic mdioIn,
    output logic mgmtSerialClockPin,
    output logic mdioOut,
    output logic mdioOe,
    output pmp_pkg::pmp_slot_s [1:0] accessSlot,
    output logic [31:0] aliveMap,
    output logic [31:0] linkMap,
    output logic [1:0] accessDoneRaw,
    output logic [1:0] accessDoneMasked,
    output logic [1:0] accessDoneMask,
    output logic carrierChangeRaw,
    output logic carrierChangeMasked,
    output logic busy
);
    import pmp_pkg::*;

    typedef struct packed {
        pmp_frame_e frm;
        logic mdc;
        logic dout;
        logic oe;
        logic [5:0] pos;
        logic [31:0] word;
        logic isRead;
        logic [1:0] owner;
        logic lastUser;
        logic rr;
        logic [4:0] pollAddr;
        logic ack;
        logic [15:0] rx;
        pmp_slot_s [1:0] slot;
        logic [31:0] alive;
        logic [31:0] link;
        logic [1:0] doneRaw;
        logic [1:0] doneMask;
        logic [1:0] doneMasked;
        logic linkRaw;
        logic linkMasked;
        logic busy;
    } pmp_state_s;

    pmp_state_s s;
    pmp_state_s next_s;
    logic tickRise;
    logic tickFall;

    // ==========================================================
    // Bus clock ticks
    pmp_clk_div #(.DIV_W(DIV_W)) uDiv (
        .clk(clk),
        .rst(rst),
        .enable(enable),
        .divider(mgmtClockDivider),
        .tickRise(tickRise),
        .tickFall(tickFall)
    );

    // Level put on the line at a bit position
    function automatic logic bitAt(input logic [31:0] word, input logic [5:0] pos);
        logic [5:0] idx;
        idx = 6'h3F - pos;
        bitAt = (pos < PMP_POS_FRAME) ? 1'b1 : word[idx[4:0]];
    endfunction

    // Whether the line is driven at a bit position
    function automatic logic driveAt(input logic isRead, input logic [5:0] pos);
        driveAt = !isRead || (pos < PMP_POS_TA);
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic pick;
        logic [4:0] addr;
        logic newLink;
        pick = 1'b0;
        addr = s.pollAddr;
        newLink = 1'b0;
        next_s = s;
        // Software side of the slots and event flags
        for (int i = 0; i < 2; i++) begin
            if (accessReqStb[i] && !s.slot[i].go) begin
                next_s.slot[i].go = accessReq.go;
                next_s.slot[i].write = accessReq.write;
                next_s.slot[i].regAddr = accessReq.regAddr;
                next_s.slot[i].phyAddr = accessReq.phyAddr;
                next_s.slot[i].data = accessReq.data;
                next_s.slot[i].ack = 1'b0;
            end
            next_s.doneMask[i] = (s.doneMask[i] & ~accessDoneMaskClear[i]) | accessDoneMaskSet[i];
            next_s.doneRaw[i] = s.doneRaw[i] & ~accessDoneRawClear[i];
        end
        next_s.linkRaw = s.linkRaw & ~carrierChangeClear;
        if (tickRise) begin
            next_s.mdc = 1'b1;
        end else if (tickFall) begin
            next_s.mdc = 1'b0;
        end
        case (s.frm)
            PMP_IDLE: begin
                next_s.oe = 1'b0;
                if (enable && tickFall) begin
                    if (!s.lastUser && (s.slot[0].go || s.slot[1].go)) begin
                        pick = s.slot[s.rr].go ? s.rr : ~s.rr;
                        next_s.owner = pick ? 2'h2 : 2'h1;
                        next_s.lastUser = 1'b1;
                        next_s.rr = ~pick;
                        next_s.isRead = !s.slot[pick].write;
                        next_s.word = {PMP_START, s.slot[pick].write ? PMP_OP_WRITE : PMP_OP_READ,
                            s.slot[pick].phyAddr, s.slot[pick].regAddr, PMP_TA_WRITE, s.slot[pick].data};
                    end else begin
                        next_s.owner = 2'h0;
                        next_s.lastUser = 1'b0;
                        next_s.isRead = 1'b1;
                        next_s.word = {PMP_START, PMP_OP_READ, s.pollAddr, PMP_STATUS_REG, PMP_TA_WRITE,
                            16'h0000};
                    end
                    next_s.pos = preambleEn ? 6'h00 : PMP_POS_FRAME;
                    next_s.ack = 1'b0;
                    next_s.dout = bitAt(next_s.word, next_s.pos);
                    next_s.oe = driveAt(next_s.isRead, next_s.pos);
                    next_s.frm = PMP_FRAME;
                end
            end
            PMP_FRAME: begin
                if (tickRise && s.isRead) begin
                    if (s.pos == PMP_POS_ACK) begin
                        next_s.ack = ~mdioIn;
                    end
                    if (s.pos >= PMP_POS_DATA) begin
                        next_s.rx = {s.rx[14:0], mdioIn};
                    end
                end
                if (tickFall) begin
                    if (s.pos == PMP_POS_LAST) begin
                        next_s.oe = 1'b0;
                        next_s.frm = PMP_FINISH;
                    end else begin
                        next_s.pos = s.pos + 6'h01;
                        next_s.dout = bitAt(s.word, next_s.pos);
                        next_s.oe = driveAt(s.isRead, next_s.pos);
                    end
                end
            end
            PMP_FINISH: begin
                next_s.frm = PMP_IDLE;
                if (s.owner == 2'h0) begin
                    addr = s.pollAddr;
                    newLink = s.ack && s.rx[PMP_LINK_BIT];
                    next_s.alive[addr] = s.ack;
                    next_s.link[addr] = newLink;
                    if (addr == monitoredPhyAddress && newLink != s.link[addr]) begin
                        next_s.linkRaw = 1'b1;
                    end
                    next_s.pollAddr = s.pollAddr + 5'h01;
                end else begin
                    pick = (s.owner == 2'h2);
                    next_s.slot[pick].go = 1'b0;
                    next_s.doneRaw[pick] = 1'b1;
                    if (s.isRead) begin
                        next_s.alive[s.slot[pick].phyAddr] = s.ack;
                        next_s.slot[pick].data = s.rx;
                        next_s.slot[pick].ack = s.ack;
                    end
                end
            end
            default: begin
                next_s.frm = PMP_IDLE;
            end
        endcase
        if (!enable) begin
            next_s.frm = PMP_IDLE;
            next_s.oe = 1'b0;
            next_s.mdc = 1'b0;
        end
        next_s.doneMasked = next_s.doneRaw & next_s.doneMask;
        next_s.linkMasked = next_s.linkRaw & carrierChangeIrqEn;
        next_s.busy = (next_s.frm != PMP_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign mgmtSerialClockPin = s.mdc;
    assign mdioOut = s.dout;
    assign mdioOe = s.oe;
    assign accessSlot = s.slot;
    assign aliveMap = s.alive;
    assign linkMap = s.link;
    assign accessDoneRaw = s.doneRaw;
    assign accessDoneMasked = s.doneMasked;
    assign accessDoneMask = s.doneMask;
    assign carrierChangeRaw = s.linkRaw;
    assign carrierChangeMasked = s.linkMasked;
    assign busy = s.busy;

endmodule

// ---- verification/pmp_phy_model.sv ----
// Partner: behavioural PHY population on the management bus
`timescale 1ns/100ps
module pmp_phy_model (
    input wire logic mdc,
    input wire logic idle,
    input wire logic mdio,
    input wire logic [31:0] presentMask,
    input wire logic [31:0] linkMask,
    output logic phyOe,
    output logic phyOut
);
    import pmp_pkg::*;
    // ==========
    // Frame decode on the clock rise
    logic [15:0] hdr = 16'hFFFF;
    logic [15:0] rd;
    logic [15:0] mem [32];
    logic [4:0] hc = 5'h00;
    logic [4:0] rg;
    logic [4:0] rgNew;
    logic [4:0] ph;
    logic [5:0] rc = 6'h00;
    logic wr = 1'h0;
    logic ans = 1'h0;
    assign rgNew = {hdr[3:0], mdio};
    assign ph = hdr[8:4];
    always @(posedge mdc or posedge idle) begin
        if (idle) begin
            hdr <= 16'hFFFF;
            hc <= 5'h00;
            rc <= 6'h00;
        end else begin
            hdr <= (rc == 6'h12) ? 16'hFFFF : {hdr[14:0], mdio};
            if (rc != 6'h00) begin
                rc <= (rc == 6'h12) ? 6'h00 : rc + 6'h01;
                if (rc == 6'h12 && wr) begin
                    mem[rg] <= {hdr[14:0], mdio};
                end
            end else if (hc != 5'h00) begin
                hc <= (hc == 5'h0D) ? 5'h00 : hc + 5'h01;
                rc <= (hc == 5'h0D) ? 6'h01 : 6'h00;
                rg <= rgNew;
                wr <= hdr[10:9] == PMP_OP_WRITE && presentMask[ph];
                ans <= hdr[10:9] == PMP_OP_READ && presentMask[ph];
                rd <= (rgNew == PMP_STATUS_REG) ? 16'(linkMask[ph]) << PMP_LINK_BIT : mem[rgNew];
            end else if ({hdr[1:0], mdio} == 3'h5) begin
                hc <= 5'h02;
            end
        end
    end
    assign phyOe = ans && rc >= 6'h02;
    assign phyOut = (rc == 6'h02) ? 1'h0 : rd[6'h12 - rc];
endmodule

// ---- verification/pmp_poller_checker.sv ----
// Checker: port assertions of the PHY management poller
`timescale 1ns/100ps
module pmp_poller_checker #(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [DIV_W-1:0] mgmtClockDivider,
    input wire logic [1:0] accessReqStb,
    input wire pmp_pkg::pmp_cmd_s accessReq,
    input wire logic carrierChangeIrqEn,
    input wire logic mgmtSerialClockPin,
    input wire logic mdioOut,
    input wire logic mdioOe,
    input wire pmp_pkg::pmp_slot_s [1:0] accessSlot,
    input wire logic [31:0] aliveMap,
    input wire logic [31:0] linkMap,
    input wire logic [1:0] accessDoneRaw,
    input wire logic [1:0] accessDoneMasked,
    input wire logic [1:0] accessDoneMask,
    input wire logic carrierChangeRaw,
    input wire logic carrierChangeMasked,
    input wire logic busy
);
    import pmp_pkg::*;
    // ==========
    // High phase length and sequences
    logic [DIV_W:0] hiCnt;
    always_ff @(posedge clk) begin
        hiCnt <= mgmtSerialClockPin ? hiCnt + 1'h1 : '0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence sLoad0;
        accessReqStb[0] && !accessSlot[0].go;
    endsequence
    sequence sHighEnd;
        enable && $fell(mgmtSerialClockPin);
    endsequence
    // ==========
    // Assertions
    AST_IDLE: assert property (!enable |=> !mdioOe && !mgmtSerialClockPin && !busy)
        else $error("active while off");
    AST_DIV: assert property (sHighEnd |-> hiCnt == mgmtClockDivider + 1)
        else $error("clock phase length");
    AST_OE_EDGE: assert property ($changed(mdioOe) |-> !mgmtSerialClockPin)
        else $error("enable moved in high phase");
    AST_HOLD: assert property (mgmtSerialClockPin && $past(mgmtSerialClockPin) |-> $stable(mdioOut))
        else $error("data moved in high phase");
    AST_DONE0: assert property (!$past(rst) && $fell(accessSlot[0].go) |-> accessDoneRaw[0])
        else $error("slot 0 done missing");
    AST_DONE1: assert property (!$past(rst) && $fell(accessSlot[1].go) |-> accessDoneRaw[1])
        else $error("slot 1 done missing");
    AST_MASKED: assert property (accessDoneMasked == (accessDoneRaw & accessDoneMask))
        else $error("done mask");
    AST_LINKEV: assert property ($rose(carrierChangeRaw) |-> carrierChangeMasked == $past(carrierChangeIrqEn))
        else $error("link event mask");
    AST_LINKMAP: assert property ((linkMap & ~aliveMap) == 32'h0000_0000)
        else $error("link without answer");
    AST_LOAD: assert property (sLoad0 |=> accessSlot[0].data == $past(accessReq.data) && !accessSlot[0].ack)
        else $error("slot load");
endmodule

bind pmp_poller pmp_poller_checker #(.DIV_W(DIV_W)) u_chk (
    .clk, .rst, .enable, .mgmtClockDivider, .accessReqStb, .accessReq, .carrierChangeIrqEn,
    .mgmtSerialClockPin, .mdioOut, .mdioOe, .accessSlot, .aliveMap, .linkMap, .accessDoneRaw,
    .accessDoneMasked, .accessDoneMask, .carrierChangeRaw, .carrierChangeMasked, .busy
);

// ---- verification/tb_top.sv ----
// Testbench: self-checking bench of the PHY management poller
`timescale 1ns/100ps
module tb_top;
    import pmp_pkg::*;
    // ==========
    // Signals and checking
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic enable = 1'h0;
    logic preambleEn = 1'h0;
    logic irqEn = 1'h1;
    logic ccClr = 1'h0;
    logic [15:0] div = 16'h0000;
    logic [1:0] stb = 2'h0;
    logic [1:0] mSet = 2'h0;
    logic [1:0] mClr = 2'h0;
    logic [1:0] rClr = 2'h0;
    logic [4:0] rg = 5'h02;
    logic [4:0] mon = 5'h05;
    logic [15:0] d;
    logic [31:0] present = 32'h0000_0028;
    logic [31:0] linkMask = 32'h0000_0008;
    pmp_cmd_s req = '0;
    logic mdioIn, mdc, mdioOut, mdioOe, busy, ccRaw, ccMasked, phyOe, phyOut;
    pmp_slot_s [1:0] slot;
    logic [31:0] alive, link;
    logic [1:0] dRaw, dMasked, dMask;
    int nErrors = 0, checks = 0, seed = 67255, lastLen = 0, curLen = 0, k, s;
    always #10 clk = ~clk;
    assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'h1);
    always @(negedge clk) begin
        if (busy) curLen++;
        else if (curLen != 0) begin
            lastLen = curLen;
            curLen = 0;
        end
    end
    pmp_poller uut (
        .clk, .rst, .enable, .preambleEn, .mgmtClockDivider(div), .accessReqStb(stb), .accessReq(req),
        .accessDoneMaskSet(mSet), .accessDoneMaskClear(mClr), .accessDoneRawClear(rClr),
        .monitoredPhyAddress(mon), .carrierChangeIrqEn(irqEn), .carrierChangeClear(ccClr), .mdioIn,
        .mgmtSerialClockPin(mdc), .mdioOut, .mdioOe, .accessSlot(slot), .aliveMap(alive), .linkMap(link),
        .accessDoneRaw(dRaw), .accessDoneMasked(dMasked), .accessDoneMask(dMask),
        .carrierChangeRaw(ccRaw), .carrierChangeMasked(ccMasked), .busy
    );
    pmp_phy_model phy (
        .mdc, .idle(!enable), .mdio(mdioIn), .presentMask(present), .linkMask, .phyOe, .phyOut
    );
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            nErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", nErrors, checks);
        if (nErrors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic expMask(input int s, input int k);
        return s == 0 && k < 2;
    endfunction
    task automatic waitGo(input int s);
        int i;
        i = 0;
        repeat (2) @(posedge clk);
        while (slot[s].go === 1'h1 && i < 4000) begin
            @(posedge clk);
            i++;
        end
        repeat (3) @(posedge clk);
        chk("go", {slot[s].go, dRaw[s]}, 2'h1);
    endtask
    task automatic xfer(input int s, input logic wr, input logic [4:0] ph, input logic [15:0] dat);
        req <= '{1'h1, wr, rg, ph, dat};
        stb[s] <= 1'h1;
        @(posedge clk);
        stb <= 2'h0;
        waitGo(s);
    endtask
    // ==========
    // Scenarios
    initial begin
        present = $random(seed) | 32'h0000_0028;
        div = 16'(PMP_DIV_FOR_MAX + {$random(seed)} % 2);
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        repeat (20) @(posedge clk);
        chk("idle", {busy, mdioOe, mdc}, 3'h0);
        enable <= 1'h1;
        repeat (34 * 68 * (div + 1)) @(posedge clk);
        chk("alive", alive, present);
        chk("link", link, present & linkMask);
        chk("evt", {ccRaw, ccMasked}, 2'h0);
        ccClr <= 1'h1;
        mon <= 5'h03;
        linkMask[3] <= 1'h0;
        @(posedge clk);
        ccClr <= 1'h0;
        repeat (34 * 68 * (div + 1)) @(posedge clk);
        chk("evt", {ccRaw, ccMasked, link[3]}, 3'h6);
        irqEn <= 1'h0;
        repeat (2) @(posedge clk);
        chk("evtmask", {ccRaw, ccMasked}, 2'h2);
        ccClr <= 1'h1;
        @(posedge clk);
        ccClr <= 1'h0;
        repeat (2) @(posedge clk);
        chk("evtclr", ccRaw, 1'h0);
        for (k = 0; k < 4; k++) begin
            s = k % 2;
            mSet <= {1'h0, k == 0};
            mClr <= {1'h0, k == 2};
            enable <= 1'h0;
            preambleEn <= k[0];
            rClr <= 2'h3;
            @(posedge clk);
            enable <= 1'h1;
            mSet <= 2'h0;
            mClr <= 2'h0;
            rClr <= 2'h0;
            rg = 5'(2 + {$random(seed)} % 30);
            d = 16'($random(seed));
            xfer(s, 1'h1, 5'h03, d);
            chk("wmask", dMasked[s], expMask(s, k));
            chk("wslot", {slot[s].write, slot[s].regAddr, slot[s].phyAddr, dMask[s]}, {1'h1, rg, 5'h03, expMask(s, k)});
            xfer(1 - s, 1'h0, 5'h03, 16'h0000);
            chk("rd", {slot[1 - s].ack, dMasked[1 - s], slot[1 - s].data}, {1'h1, expMask(1 - s, k), d});
            chk("pre", lastLen > 96 * (div + 1), k[0]);
        end
        present[5] <= 1'h0;
        rg = PMP_STATUS_REG;
        xfer(1, 1'h0, 5'h05, 16'h0000);
        chk("absent", {slot[1].ack, alive[5]}, 2'h0);
        linkMask[3] <= 1'h1;
        rClr <= 2'h3;
        @(posedge clk);
        rClr <= 2'h0;
        req <= '{1'h1, 1'h0, PMP_STATUS_REG, 5'h03, 16'h0000};
        stb <= 2'h3;
        @(posedge clk);
        stb <= 2'h0;
        waitGo(0);
        chk("rrorder", slot[1].go, 1'h1);
        waitGo(1);
        chk("rr", {dRaw, slot[0].data, slot[1].data}, {2'h3, 16'h0004, 16'h0004});
        results();
    end
    initial begin
        repeat (90000) @(posedge clk);
        nErrors++;
        results();
    end
endmodule
